//--- design/sync_serial_pkg.sv
// Constants for the clocked synchronous serial channel
// Operation
// - Internal clock is source over 2(m+1)
// - Clock source select 1 takes external clock
// - Transmit starts on enable, data, clear-to-send
// - Receive also needs receive enable set
// - Transmit irq on load or on completion
// - Receive irq when character reaches buffer
// - Overrun when seventh bit arrives unread
// - Overrun leaves no receive irq request
// - Polarity chooses drive and sample edges
// - Data pin idles high, or released
// - Bit order selects LSB or MSB first
// - Count source picks f1, f8, f2n
// - Clear-to-send gating can be disabled
// - Shift register empty flag readable
// - Buffer empty and receive complete flags
// - Continuous receive rearms on buffer read
// - Logic inversion of transmit and receive data
// - Mode 000b clears channel state
// - Continuous receive read clears buffer empty
// - Ready-to-send low when ready, high once transfer starts
// - Internal clock pin idles low between transfers
package sync_serial_pkg;
  localparam logic [2:0] ADDR_MODE   = 3'h0; // serial_mode_reg
  localparam logic [2:0] ADDR_CTRL0  = 3'h1; // serial_control0_reg
  localparam logic [2:0] ADDR_CTRL1  = 3'h2; // serial_control1_reg
  localparam logic [2:0] ADDR_DIV    = 3'h3; // bit_rate_divider
  localparam logic [2:0] ADDR_TXBUF  = 3'h4; // transmit_buffer
  localparam logic [2:0] ADDR_RXBUF  = 3'h5; // receive_buffer, overrun in bit 12
  localparam logic [2:0] ADDR_IRQ    = 3'h6; // irq request flags, write 1 to clear
  localparam logic [2:0] MODE_OFF    = 3'h0;
  localparam logic [2:0] MODE_SYNC   = 3'h1;
  // serial_mode_reg fields
  localparam int MR_CLOCK_SOURCE_SELECT_BIT = 3;
  // serial_control0_reg fields
  localparam int C0_CLK_LSB   = 0;
  localparam int C0_SHIFT_REGISTER_EMPTY_FLAG_BIT = 3;
  localparam int C0_CRD_BIT   = 4;
  localparam int C0_RTS_BIT   = 5;
  localparam int C0_CLOCK_POLARITY_SELECT_BIT = 6;
  localparam int C0_BIT_ORDER_SELECT_BIT = 7;
  // serial_control1_reg fields
  localparam int C1_TE_BIT    = 0;
  localparam int C1_TI_BIT    = 1;
  localparam int C1_RE_BIT    = 2;
  localparam int C1_RI_BIT    = 3;
  localparam int C1_IRS_BIT   = 4;
  localparam int C1_RRM_BIT   = 5;
  localparam int C1_LCH_BIT   = 6;
  localparam int C1_OD_BIT    = 7;
  localparam int RB_OER_BIT   = 12;
  // Count source choices and reset values
  localparam logic [1:0] CS_F1  = 2'h0;
  localparam logic [1:0] CS_F8  = 2'h1;
  localparam logic [1:0] CS_F2N = 2'h2;
  localparam logic [7:0] F8_DIV = 8'h07;
  localparam logic [7:0] CTRL0_RESET = 8'h08;
  localparam logic [7:0] CTRL1_RESET = 8'h02;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] OVR_BIT  = 4'h6;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOW   = 2'b01,
    ST_HIGH  = 2'b10
  } xfer_state_t;
endpackage

//--- design/sync_serial_channel.sv
// Synchronous serial channel: registers, bit clock, shifters
`timescale 1ns/10ps
module sync_serial_channel
  import sync_serial_pkg::*;
(
  input  wire logic        clk,           // 200 MHz system clock
  input  wire logic        reset,         // Synchronous, active high
  input  wire logic [2:0]  addr,          // Register index
  input  wire logic [15:0] wdata,         // Write data
  input  wire logic        wr,            // Write strobe
  input  wire logic        rd,            // Read strobe
  output logic [15:0]      rdata,         // Read data, cycle after rd
  input  wire logic [7:0]  f2n_div,       // Divider that forms f2n
  input  wire logic        serial_clock_in,  // Clock pin level in
  output logic             serial_clock_out, // Clock pin level out
  output logic             serial_clock_oe,  // Clock pin driven
  output logic             transmit_data_out,// Data pin level
  output logic             transmit_data_oe, // Data pin driven
  input  wire logic        receive_data_pin, // Serial data in
  input  wire logic        clear_to_send_pin,// Handshake in, active low
  output logic             ready_to_send_n,  // Handshake out, active low
  output logic             tx_irq,        // Transmit irq request flag
  output logic             rx_irq         // Receive irq request flag
);
  // Register state
  logic [7:0] mode_q, mode_d, c0_q, c0_d, c1_q, c1_d, div_q, div_d;
  logic [7:0] txbuf_q, txbuf_d, rxbuf_q, rxbuf_d, tsh_q, tsh_d, rsh_q, rsh_d;
  logic [7:0] pre_q, pre_d, brg_q, brg_d;
  logic [3:0] bit_q, bit_d;
  logic       oer_q, oer_d, txirq_q, txirq_d, rxirq_q, rxirq_d, unread_q, unread_d;
  logic       txd_q, txd_d, sclk_q, sclk_d, rts_q, rts_d, ext_q, ext_d;
  logic [15:0] rdata_d;
  xfer_state_t st_q, st_d;

  // Decoded controls
  logic on, ext, pol, msb, te, re, ti, cts_gate_disable, cts_ok, start, tick, src_en;
  logic drive_edge, sample_edge, rx_bit, tx_bit;
  logic wr_mode, wr_c0, wr_c1, wr_div, wr_tb, wr_irq, rd_rb;
  always_comb begin
    on  = (mode_q[2:0] == MODE_SYNC);
    ext = mode_q[MR_CLOCK_SOURCE_SELECT_BIT];
    pol = c0_q[C0_CLOCK_POLARITY_SELECT_BIT];
    msb = c0_q[C0_BIT_ORDER_SELECT_BIT];
    cts_gate_disable = c0_q[C0_CRD_BIT];
    te  = c1_q[C1_TE_BIT];
    ti  = c1_q[C1_TI_BIT];
    re  = c1_q[C1_RE_BIT];
    cts_ok = cts_gate_disable || !clear_to_send_pin;
    // Receive rides on transmit: receive needs transmit armed too
    start = on && st_q == ST_IDLE && te && !ti && cts_ok;
    wr_mode = wr && addr == ADDR_MODE;
    wr_c0   = wr && addr == ADDR_CTRL0;
    wr_c1   = wr && addr == ADDR_CTRL1;
    wr_div  = wr && addr == ADDR_DIV;
    wr_tb   = wr && addr == ADDR_TXBUF;
    wr_irq  = wr && addr == ADDR_IRQ;
    rd_rb   = rd && addr == ADDR_RXBUF;
  end

  // Count source prescaler and divider tick, source over 2(m+1)
  always_comb begin
    pre_d = 8'h00;
    src_en = 1'b1;
    if (c0_q[1:0] == CS_F8) begin
      src_en = (pre_q == F8_DIV);
      pre_d  = src_en ? 8'h00 : pre_q + 8'h01;
    end else if (c0_q[1:0] == CS_F2N) begin
      src_en = (pre_q >= f2n_div);
      pre_d  = src_en ? 8'h00 : pre_q + 8'h01;
    end
    tick  = 1'b0;
    brg_d = brg_q;
    if (st_q == ST_IDLE || wr_div) begin
      brg_d = div_q;
    end else if (src_en) begin
      tick  = (brg_q == 8'h00);
      brg_d = tick ? div_q : brg_q - 8'h01;
    end
  end

  // Edge events: internal half periods or external pin transitions
  always_comb begin
    ext_d = serial_clock_in;
    drive_edge  = 1'b0;
    sample_edge = 1'b0;
    if (ext) begin
      // Idle level is high at polarity 0, so first edge drives
      drive_edge  = (ext_q != pol) && (serial_clock_in == pol);
      sample_edge = (ext_q == pol) && (serial_clock_in != pol);
    end else begin
      drive_edge  = tick && st_q == ST_HIGH;
      sample_edge = tick && st_q == ST_LOW;
    end
  end

  // Transfer state machine and shifters
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    tsh_d = tsh_q;
    rsh_d = rsh_q;
    txd_d = txd_q;
    sclk_d = sclk_q;
    rts_d = rts_q;
    rxbuf_d = rxbuf_q;
    oer_d = oer_q;
    unread_d = unread_q;
    txirq_d = txirq_q;
    rxirq_d = rxirq_q;
    c1_d = c1_q;
    tx_bit = msb ? tsh_q[7] : tsh_q[0];
    rx_bit = receive_data_pin ^ c1_q[C1_LCH_BIT];
    rts_d = !(on && re && st_q == ST_IDLE);
    if (wr_c1) c1_d = {wdata[7:4], c1_q[C1_RI_BIT], wdata[2], c1_q[C1_TI_BIT], wdata[0]};
    if (wr_tb) c1_d[C1_TI_BIT] = 1'b0;
    if (rd_rb) begin
      unread_d = 1'b0;
      c1_d[C1_RI_BIT] = 1'b0;
      if (c1_q[C1_RRM_BIT]) c1_d[C1_TI_BIT] = 1'b0;
    end
    if (wr_irq) begin
      txirq_d = txirq_q & ~wdata[0];
      rxirq_d = rxirq_q & ~wdata[1];
    end
    case (st_q)
      ST_IDLE: begin
        sclk_d = 1'b0;
        if (start) begin
          tsh_d = txbuf_q ^ {8{c1_q[C1_LCH_BIT]}};
          c1_d[C1_TI_BIT] = 1'b1;
          bit_d = 4'h0;
          st_d = ST_HIGH;
          sclk_d = ~pol;
          if (!c1_q[C1_IRS_BIT]) txirq_d = 1'b1;
        end
      end
      default: begin
        if (!ext && tick) sclk_d = ~sclk_q;
        if (!ext && tick) st_d = (st_q == ST_LOW) ? ST_HIGH : ST_LOW;
        if (drive_edge) begin
          txd_d = tx_bit;
          rts_d = 1'b1;
        end
        if (sample_edge) begin
          rsh_d = msb ? {rsh_q[6:0], rx_bit} : {rx_bit, rsh_q[7:1]};
          tsh_d = msb ? {tsh_q[6:0], 1'b0} : {1'b0, tsh_q[7:1]};
          bit_d = bit_q + 4'h1;
          if (bit_q == OVR_BIT && unread_q && re) oer_d = 1'b1;
          if (bit_q == LAST_BIT) begin
            st_d = ST_IDLE;
            if (c1_q[C1_IRS_BIT]) txirq_d = 1'b1;
            if (re) begin
              rxbuf_d = rsh_d;
              unread_d = 1'b1;
              c1_d[C1_RI_BIT] = 1'b1;
              if (!(oer_q || (unread_q && bit_q >= OVR_BIT))) rxirq_d = 1'b1;
            end
          end
        end
      end
    endcase
    if (!re) oer_d = 1'b0;
    if (!on) begin
      st_d = ST_IDLE;
      sclk_d = 1'b0;
      txd_d = 1'b1;
      oer_d = 1'b0;
      unread_d = 1'b0;
      c1_d[C1_TI_BIT] = 1'b1;
      c1_d[C1_RI_BIT] = 1'b0;
    end else if (st_q == ST_IDLE && !start) begin
      txd_d = 1'b1;
    end
  end

  // Plain register writes
  always_comb begin
    mode_d  = wr_mode ? wdata[7:0] : mode_q;
    c0_d    = wr_c0 ? {wdata[7:4], c0_q[C0_SHIFT_REGISTER_EMPTY_FLAG_BIT], wdata[2:0]} : c0_q;
    c0_d[C0_SHIFT_REGISTER_EMPTY_FLAG_BIT] = (st_d == ST_IDLE);
    div_d   = wr_div ? wdata[7:0] : div_q;
    txbuf_d = wr_tb ? wdata[7:0] : txbuf_q;
    rdata_d = 16'h0000;
    if (rd) begin
      if (addr == ADDR_MODE) rdata_d = {8'h00, mode_q};
      else if (addr == ADDR_CTRL0) rdata_d = {8'h00, c0_q};
      else if (addr == ADDR_CTRL1) rdata_d = {8'h00, c1_q};
      else if (addr == ADDR_DIV) rdata_d = {8'h00, div_q};
      else if (addr == ADDR_RXBUF) rdata_d = {3'h0, oer_q, 4'h0, rxbuf_q};
      else if (addr == ADDR_IRQ) rdata_d = {14'h0000, rxirq_q, txirq_q};
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= 8'h00; c0_q <= CTRL0_RESET; c1_q <= CTRL1_RESET; div_q <= 8'h00;
      txbuf_q <= 8'h00; rxbuf_q <= 8'h00; tsh_q <= 8'h00; rsh_q <= 8'h00;
      pre_q <= 8'h00; brg_q <= 8'h00; bit_q <= 4'h0; oer_q <= 1'b0;
      txirq_q <= 1'b0; rxirq_q <= 1'b0; unread_q <= 1'b0; txd_q <= 1'b1;
      sclk_q <= 1'b0; rts_q <= 1'b1; ext_q <= 1'b0; st_q <= ST_IDLE;
      rdata <= 16'h0000;
    end else begin
      mode_q <= mode_d; c0_q <= c0_d; c1_q <= c1_d; div_q <= div_d;
      txbuf_q <= txbuf_d; rxbuf_q <= rxbuf_d; tsh_q <= tsh_d; rsh_q <= rsh_d;
      pre_q <= pre_d; brg_q <= brg_d; bit_q <= bit_d; oer_q <= oer_d;
      txirq_q <= txirq_d; rxirq_q <= rxirq_d; unread_q <= unread_d; txd_q <= txd_d;
      sclk_q <= sclk_d; rts_q <= rts_d; ext_q <= ext_d; st_q <= st_d;
      rdata <= rdata_d;
    end
  end

  // Pin outputs; open drain releases instead of driving high
  always_ff @(posedge clk) begin
    if (reset) begin
      serial_clock_out <= 1'b0; serial_clock_oe <= 1'b0;
      transmit_data_out <= 1'b1; transmit_data_oe <= 1'b0;
      ready_to_send_n <= 1'b1; tx_irq <= 1'b0; rx_irq <= 1'b0;
    end else begin
      serial_clock_out  <= sclk_d;
      serial_clock_oe   <= on && !ext;
      transmit_data_out <= txd_d;
      transmit_data_oe  <= on && !(c1_d[C1_OD_BIT] && txd_d);
      ready_to_send_n   <= c0_d[C0_RTS_BIT] ? rts_d : 1'b1;
      tx_irq            <= txirq_d;
      rx_irq            <= rxirq_d;
    end
  end
endmodule // sync_serial_channel

//--- test/sync_serial_props.sv
// Port-level checker for the synchronous serial channel
`timescale 1ns/10ps
module sync_serial_props
  import sync_serial_pkg::*;
(
  input wire logic        clk, reset, wr, rd,     // Clock, reset, strobes
  input wire logic [2:0]  addr,                   // Register index
  input wire logic [15:0] wdata, rdata,           // Bus data
  input wire logic [7:0]  f2n_div,                // Prescale input
  input wire logic        serial_clock_in, serial_clock_out, serial_clock_oe, // Clock pin
  input wire logic        transmit_data_out, transmit_data_oe, receive_data_pin, // Data pins
  input wire logic        clear_to_send_pin, ready_to_send_n, tx_irq, rx_irq // Handshake, irqs
);
  logic [3:0] mode_q;
  logic [1:0] cs_q;
  logic [7:0] div_q;
  // Shadow of the settings the assertions depend on
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= 4'h0;
      cs_q   <= 2'h0;
      div_q  <= 8'h00;
    end else if (wr) begin
      if (addr == ADDR_MODE) mode_q <= wdata[3:0];
      if (addr == ADDR_CTRL0) cs_q <= wdata[1:0];
      if (addr == ADDR_DIV) div_q <= wdata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Three-cycle settle covers the mode register plus the registered pins
  a_reset_idle: assert property (disable iff (1'b0) reset |=> !serial_clock_out
    && transmit_data_out && ready_to_send_n && !tx_irq && !rx_irq) else $error("pins not idle");
  a_unmapped_zero: assert property (rd && addr == 3'h7 |=> rdata == 16'h0)
    else $error("unmapped read nonzero");
  a_quiet_rdata: assert property (!rd |=> rdata == 16'h0) else $error("rdata without read");
  a_tx_irq_hold: assert property (tx_irq && !(wr && addr == ADDR_IRQ && wdata[0]) |=> tx_irq)
    else $error("tx irq dropped");
  a_rx_irq_hold: assert property (rx_irq && !(wr && addr == ADDR_IRQ && wdata[1]) |=> rx_irq)
    else $error("rx irq dropped");
  a_off_data_float: assert property ((mode_q[2:0] == MODE_OFF)[*3] |-> !transmit_data_oe)
    else $error("data pin driven while off");
  a_ext_clk_input: assert property ((mode_q[3])[*3] |-> !serial_clock_oe)
    else $error("clock pin driven with external clock");
  a_clk_idle_off: assert property ((mode_q[2:0] != MODE_SYNC)[*3] |-> !serial_clock_out)
    else $error("clock pin not low while off");
  a_clk_low_min: assert property ($fell(serial_clock_out) && cs_q == CS_F1 && div_q == 8'h01
    |=> !serial_clock_out) else $error("clock low phase too short");
  c_rx_done: cover property ($rose(rx_irq));
  c_tx_done: cover property ($rose(tx_irq));
  c_clk_run: cover property ($fell(serial_clock_out));
endmodule // sync_serial_props
bind sync_serial_channel sync_serial_props u_sync_serial_props (.clk(clk), .reset(reset),
  .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata), .f2n_div(f2n_div),
  .serial_clock_in(serial_clock_in), .serial_clock_out(serial_clock_out),
  .serial_clock_oe(serial_clock_oe), .transmit_data_out(transmit_data_out),
  .transmit_data_oe(transmit_data_oe), .receive_data_pin(receive_data_pin),
  .clear_to_send_pin(clear_to_send_pin), .ready_to_send_n(ready_to_send_n),
  .tx_irq(tx_irq), .rx_irq(rx_irq));

//--- test/serial_partner.sv
// Remote synchronous serial device on the far side of the link
`timescale 1ns/10ps
module serial_partner (
  input  wire logic       sclk,      // Link clock from the channel
  input  wire logic       pol,       // Clock polarity in use
  input  wire logic       sdi,       // Data from the channel
  input  wire logic       load,      // Rising edge loads send_byte
  input  wire logic [7:0] send_byte, // Next character to send
  output logic            sdo,       // Data to the channel
  output logic [7:0]      got        // Captured bits, first one ends in bit 7
);
  logic [7:0] sh = 8'h00;
  logic       first = 1'b1;
  initial sdo = 1'b1;
  initial got = 8'h00;
  // First bit must stand before the first sampling edge
  always @(posedge load) begin
    sh = send_byte;
    sdo = sh[7];
    first = 1'b1;
  end
  // Sample on one edge, shift on the other; the first drive edge keeps bit one,
  // since at polarity 0 the idle-low clock makes a rise before any data
  always @(sclk) begin
    if ((sclk ^ pol) === 1'b1) begin
      got = {got[6:0], sdi};
    end else if ((sclk ^ pol) === 1'b0) begin
      if (first) begin
        first = 1'b0;
      end else begin
        sh = {sh[6:0], ~sh[7]};
        sdo = sh[7];
      end
    end
  end
endmodule // serial_partner

//--- test/tb_top.sv
// Self-checking bench for the synchronous serial channel
`timescale 1ns/10ps
module tb_top
  import sync_serial_pkg::*;
;
  logic clk = 0, reset = 1, wr = 0, rd = 0, cts_n = 1, pol = 0, load = 0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0, v;
  logic [15:0] rdata;
  logic [7:0] b, p, c0, c1, got, send;
  logic sco, scoe, tdo, tdoe, rdp, rts_n, tx_irq, rx_irq;
  int n_fail = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  sync_serial_channel u_sync_serial_channel (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .f2n_div(8'h03),
    .serial_clock_in(~pol), .serial_clock_out(sco), .serial_clock_oe(scoe),
    .transmit_data_out(tdo), .transmit_data_oe(tdoe), .receive_data_pin(rdp),
    .clear_to_send_pin(cts_n), .ready_to_send_n(rts_n), .tx_irq(tx_irq), .rx_irq(rx_irq));
  serial_partner u_serial_partner (.sclk(sco), .pol(pol), .sdi(tdo), .load(load),
    .send_byte(send), .sdo(rdp), .got(got));
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait on an irq flag; running out ends the run
  task automatic wait_sig(input logic sel);
    for (int n = 0; n < 400; n++) begin
      @(posedge clk);
      #1;
      if ((sel ? tx_irq : rx_irq) === 1'b1) return;
    end
    n_fail++;
    $display("[ERR] %0t wait ran out", $time);
    tally_and_finish();
  endtask
  // Loads the partner, then control1, then the buffer write that starts the transfer;
  // control1 first so a still-set transmit enable cannot start with stale settings
  task automatic xfer(input logic [7:0] tb_b, input logic [7:0] pb, input logic [7:0] c);
    send = pb;
    load = 1'b1;
    #1 load = 1'b0;
    wr_reg(ADDR_CTRL1, {8'h0, c});
    wr_reg(ADDR_TXBUF, {8'h0, tb_b});
  endtask
  // Expected byte after bit order and inversion
  function automatic logic [7:0] fmt(input logic [7:0] x, input logic msb, input logic inv);
    logic [7:0] r;
    r = x;
    if (!msb) r = {<<{x}};
    return inv ? ~r : r;
  endfunction
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd_reg(ADDR_CTRL0, v); chk(v, {8'h0, CTRL0_RESET});
    rd_reg(ADDR_CTRL1, v); chk(v, {8'h0, CTRL1_RESET});
    rd_reg(3'h7, v); chk(v, 16'h0);
    $display("reset test done");
    wr_reg(ADDR_MODE, 16'h0009);
    repeat (4) @(posedge clk);
    wr_reg(ADDR_MODE, 16'h0001);
    wr_reg(ADDR_DIV, 16'h0001);
    // Every mix of bit order and inversion, irq source following bit order and polarity their XOR; CTS held off but not gating
    for (int i = 0; i < 4; i++) begin
      pol = i[0] ^ i[1];
      c0 = {i[0], pol, 2'b01, 2'b00, CS_F1};
      c1 = {1'b0, i[1], 1'b0, i[0], 4'b0101};
      b = 8'h1d + 8'(i * 37);
      p = {b[3:0], b[7:4]} ^ 8'h96;
      wr_reg(ADDR_CTRL0, {8'h0, c0});
      wr_reg(ADDR_IRQ, 16'h0003);
      xfer(b, p, c1);
      wait_sig(1'b0);
      wait_sig(1'b1);
      chk({8'h0, got}, {8'h0, fmt(b, i[0], i[1])});
      rd_reg(ADDR_CTRL1, v); chk(v, {8'h0, c1 | 8'h0a});
      rd_reg(ADDR_CTRL0, v); chk(v, {8'h0, c0 | 8'h08});
      rd_reg(ADDR_RXBUF, v); chk(v, {8'h0, fmt(p, i[0], i[1])});
      chk({14'h0, tdoe, rts_n}, 16'h0003);
      $display("transfer test %0d done", i);
    end
    pol = 1'b0;
    wr_reg(ADDR_CTRL0, 16'h0000);
    wr_reg(ADDR_IRQ, 16'h0003);
    xfer(8'h81, 8'h42, 8'h15);
    repeat (60) @(posedge clk);
    chk({15'h0, tx_irq}, 16'h0000);
    cts_n <= 1'b0;
    wait_sig(1'b1);
    wr_reg(ADDR_IRQ, 16'h0003);
    xfer(8'h7e, 8'h18, 8'h15);
    wait_sig(1'b1);
    chk({15'h0, rx_irq}, 16'h0000);
    rd_reg(ADDR_RXBUF, v); chk(v & 16'h1000, 16'h1000);
    wr_reg(ADDR_CTRL1, 16'h0000);
    wr_reg(ADDR_MODE, 16'h0000);
    wr_reg(ADDR_MODE, 16'h0001);
    rd_reg(ADDR_RXBUF, v); chk(v & 16'h1000, 16'h0000);
    $display("overrun test done");
    tally_and_finish();
  end
endmodule // tb_top
